/* File: stepper_front_pkg.sv */
package stepper_front_pkg;
    // Step angle and home position
    localparam int ANGLE_W = 6;
    localparam logic [5:0] HOME_ANGLE = 6'h08;
    // Phase sign boundaries on the step angle
    localparam logic [5:0] A_POS_BELOW = 6'h10;
    localparam logic [5:0] A_POS_FROM = 6'h30;
    localparam logic [5:0] B_POS_BELOW = 6'h20;
    // Step increments per resolution, in sixteenth steps
    localparam logic [5:0] INC_FULL = 6'h10;
    localparam logic [5:0] INC_HALF = 6'h08;
    localparam logic [5:0] INC_QUARTER = 6'h04;
    localparam logic [5:0] INC_EIGHTH = 6'h02;
    localparam logic [5:0] INC_SIXTEENTH = 6'h01;
    // Serial word
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] WORD_LEN = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SLEEP_WIDTH_US = 40;
    localparam int SLEEP_CYCLES = (SLEEP_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 14;
    // Microstep resolutions
    typedef enum logic [2:0] {
        RES_FULL,
        RES_HALF,
        RES_QUARTER,
        RES_EIGHTH,
        RES_SIXTEENTH
    } step_res_t;
    // Reset pin handling
    typedef enum logic [1:0] {
        RS_IDLE,
        RS_LOW,
        RS_SLEEP
    } rst_state_t;
    // Asynchronous pins sampled together
    typedef struct packed {
        logic step;
        logic dir;
        logic msel;
        logic rst_n;
        logic ov;
        logic uvl;
        logic short_det;
    } pin_bus_t;
endpackage

/* File: stepper_step_serial_front_end.sv */
`timescale 1ns/1ps
module stepper_step_serial_front_end
    import stepper_front_pkg::*;
#(
    parameter int SLEEP_CYCLES_P = SLEEP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Host pins
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic microstep_select_in,
    input wire logic fault_clear_sleep_n,
    // Mode and resolution control
    input wire logic serial_mode_in,
    input wire logic res_cfg_valid,
    input wire step_res_t res_cfg,
    // Analog monitor results
    input wire logic vbb_ov_in,
    input wire logic vreg_uvl_in,
    input wire logic short_det_in,
    // Position outputs
    output logic [ANGLE_W-1:0] step_angle_r,
    output logic dir_applied_r,
    output step_res_t step_res_r,
    // Bridge drive
    output logic phase_a_plus,
    output logic phase_a_minus,
    output logic phase_b_plus,
    output logic phase_b_minus,
    output logic bridge_enable_r,
    // Serial word
    output logic [WORD_BITS-1:0] serial_word_r,
    output logic serial_word_valid_r,
    // Status
    output logic sleep_active_r,
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers
    pin_bus_t pin_raw;
    pin_bus_t sync1_r;
    pin_bus_t sync2_r;
    pin_bus_t sync3_r;

    assign pin_raw = '{step: step_in, dir: dir_in, msel: microstep_select_in,
                       rst_n: fault_clear_sleep_n, ov: vbb_ov_in,
                       uvl: vreg_uvl_in, short_det: short_det_in};

    always_ff @(posedge ref_clk) begin
        sync1_r <= pin_raw;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    wire logic step_rise = sync2_r.step & ~sync3_r.step;
    wire logic strobe_fall = ~sync2_r.step & sync3_r.step;
    wire logic strobe_rise = step_rise;
    wire logic sck_rise = sync2_r.msel & ~sync3_r.msel;
    wire logic rst_low = ~sync2_r.rst_n;

    ////////////////////////////////////////////////////////////////////////
    // Resolution and stepping
    logic [ANGLE_W-1:0] step_inc;
    logic [ANGLE_W-1:0] angle_nxt;
    logic strap_load_r;

    always_comb begin
        unique case (step_res_r)
            RES_FULL: step_inc = INC_FULL;
            RES_HALF: step_inc = INC_HALF;
            RES_QUARTER: step_inc = INC_QUARTER;
            RES_EIGHTH: step_inc = INC_EIGHTH;
            RES_SIXTEENTH: step_inc = INC_SIXTEENTH;
            default: step_inc = INC_SIXTEENTH;
        endcase
    end

    wire logic step_take = step_rise & ~serial_mode_in;
    assign angle_nxt = sync2_r.dir ? step_angle_r + step_inc : step_angle_r - step_inc;

    // strap caught in reset and first edge after
    always_ff @(posedge ref_clk) begin
        strap_load_r <= sys_rst;
        if (sys_rst | strap_load_r) begin
            step_res_r <= sync2_r.msel ? RES_QUARTER : RES_HALF;
        end else if (res_cfg_valid) begin
            step_res_r <= res_cfg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            step_angle_r <= HOME_ANGLE;
            dir_applied_r <= 1'b0;
        end else if (step_take) begin
            step_angle_r <= angle_nxt;
            dir_applied_r <= sync2_r.dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial word capture
    logic [CNT_W-1:0] bit_cnt_r;
    logic [WORD_BITS-1:0] shift_r;
    logic serial_fault_r;

    // strobe high blocks clock and data
    wire logic ser_open = serial_mode_in & ~sync2_r.step;
    wire logic ser_bit = ser_open & sck_rise;
    wire logic word_end = serial_mode_in & strobe_rise;
    wire logic word_good = word_end & (bit_cnt_r == WORD_LEN);
    wire logic word_bad = word_end & (bit_cnt_r != WORD_LEN);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bit_cnt_r <= '0;
            shift_r <= '0;
        end else if (serial_mode_in & strobe_fall) begin
            bit_cnt_r <= '0;
        end else if (ser_bit) begin
            shift_r <= {shift_r[WORD_BITS-2:0], sync2_r.dir};
            bit_cnt_r <= (bit_cnt_r == CNT_MAX) ? bit_cnt_r : bit_cnt_r + 1'b1;
        end
    end

    // only a 16-edge access is delivered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            serial_word_r <= '0;
            serial_word_valid_r <= 1'b0;
        end else begin
            serial_word_valid_r <= word_good;
            if (word_good) begin
                serial_word_r <= shift_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pin: fault clear and sleep
    rst_state_t rst_state_r;
    logic [RST_CNT_W-1:0] low_cnt_r;
    wire logic [RST_CNT_W-1:0] sleep_lim = RST_CNT_W'(SLEEP_CYCLES_P - 1);
    wire logic low_long = low_cnt_r >= sleep_lim;
    wire logic fault_clear = (rst_state_r == RS_LOW) & ~rst_low;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rst_state_r <= RS_IDLE;
            low_cnt_r <= '0;
        end else begin
            unique case (rst_state_r)
                RS_IDLE: begin
                    low_cnt_r <= '0;
                    if (rst_low) begin
                        rst_state_r <= RS_LOW;
                    end
                end
                RS_LOW: begin
                    low_cnt_r <= low_cnt_r + 1'b1;
                    if (!rst_low) begin
                        rst_state_r <= RS_IDLE;
                    end else if (low_long) begin
                        rst_state_r <= RS_SLEEP;
                    end
                end
                RS_SLEEP: begin
                    if (!rst_low) begin
                        rst_state_r <= RS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleep_active_r <= 1'b0;
        end else begin
            sleep_active_r <= (rst_state_r == RS_SLEEP) & rst_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Faults and diagnostic output
    logic short_lat_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            short_lat_r <= 1'b0;
            serial_fault_r <= 1'b0;
        end else begin
            short_lat_r <= sync2_r.short_det | (short_lat_r & ~fault_clear);
            serial_fault_r <= word_bad | (serial_fault_r & ~fault_clear);
        end
    end

    wire logic lockout = sync2_r.ov | sync2_r.uvl;
    wire logic fault_any = lockout | short_lat_r | serial_fault_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_flag_n_out <= 1'b0;
            fault_flag_n_oe_n <= 1'b1;
        end else begin
            fault_flag_n_out <= 1'b0;
            fault_flag_n_oe_n <= ~fault_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bridge drive
    wire logic a_pos = (step_angle_r < A_POS_BELOW) | (step_angle_r >= A_POS_FROM);
    wire logic b_pos = step_angle_r < B_POS_BELOW;
    wire logic drive_ok = ~lockout & ~sleep_active_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bridge_enable_r <= 1'b0;
            phase_a_plus <= 1'b0;
            phase_a_minus <= 1'b0;
            phase_b_plus <= 1'b0;
            phase_b_minus <= 1'b0;
        end else begin
            bridge_enable_r <= drive_ok;
            phase_a_minus <= drive_ok & a_pos;
            phase_a_plus <= drive_ok & ~a_pos;
            phase_b_minus <= drive_ok & b_pos;
            phase_b_plus <= drive_ok & ~b_pos;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // home after reset
    chk_home_after_reset: assert property (@(posedge ref_clk)
        sys_rst |=> step_angle_r == HOME_ANGLE)
        else $error("angle not home after reset");

    chk_step_increment: assert property (@(posedge ref_clk) disable iff (sys_rst)
        step_take && sync2_r.dir |=> step_angle_r == $past(step_angle_r) + $past(step_inc))
        else $error("step up wrong");

    chk_step_decrement: assert property (@(posedge ref_clk) disable iff (sys_rst)
        step_take && !sync2_r.dir |=> step_angle_r == $past(step_angle_r) - $past(step_inc))
        else $error("step down wrong");

    chk_angle_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !step_take |=> $stable(step_angle_r) && $stable(dir_applied_r))
        else $error("angle moved without step");

    chk_strap_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
        strap_load_r |=> (step_res_r == ($past(sync2_r.msel) ? RES_QUARTER : RES_HALF)))
        else $error("strap mode wrong");

    chk_strobe_ignore: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sync2_r.step |=> $stable(shift_r))
        else $error("shift moved with strobe high");

    chk_word_length: assert property (@(posedge ref_clk) disable iff (sys_rst)
        serial_word_valid_r |-> $past(bit_cnt_r) == WORD_LEN && serial_word_r == $past(shift_r))
        else $error("word delivered with wrong length");

    chk_sleep_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rst_state_r == RS_LOW && rst_low && low_long ##1 rst_low |=> sleep_active_r)
        else $error("no sleep after long reset");

    chk_short_no_sleep: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fault_clear |=> !sleep_active_r && (short_lat_r == $past(sync2_r.short_det)))
        else $error("short pulse mishandled");

    chk_fault_flag_n_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fault_any |=> !fault_flag_n_oe_n && !fault_flag_n_out)
        else $error("fault_flag_n not low on fault");

    chk_lockout_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        lockout |=> !bridge_enable_r && !phase_a_plus && !phase_a_minus && !phase_b_plus && !phase_b_minus)
        else $error("bridges on during lockout");

    chk_phase_polarity: assert property (@(posedge ref_clk) disable iff (sys_rst)
        drive_ok |=> phase_a_minus == $past(a_pos) && phase_b_plus == !$past(b_pos))
        else $error("phase polarity wrong");

endmodule // stepper_step_serial_front_end

/* File: host_pin_model.sv */
`timescale 1ns/1ps
module host_pin_model (
    // Host pins
    output logic step_pin,
    output logic dir_pin,
    output logic sck_pin
);
    localparam time HALF_SCK = 32ns;
    initial begin
        step_pin = 1'b0;
        dir_pin = 1'b0;
        sck_pin = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Strap level on the select pin
    task automatic set_strap(input logic v);
        sck_pin = v;
    endtask
    // Direction level alone
    task automatic set_dir(input logic v);
        dir_pin = v;
    endtask
    // Step pulse, gap sets setup, high and low times
    task automatic step_pulse(input logic d, input int gap_ns);
        dir_pin = d;
        #(gap_ns);
        step_pin = 1'b1;
        #(gap_ns);
        step_pin = 1'b0;
        #(gap_ns);
    endtask
    ////////////////////////////////////////////////////////////////
    // clock high at strobe rise
    task automatic strobe_idle();
        sck_pin = 1'b1;
        #(HALF_SCK);
        step_pin = 1'b1;
        #(HALF_SCK);
    endtask
    // Clock activity while strobe is high
    task automatic noise();
        repeat (3) begin
            sck_pin = 1'b0;
            dir_pin = ~dir_pin;
            #(HALF_SCK);
            sck_pin = 1'b1;
            #(HALF_SCK);
        end
    endtask
    task automatic send_frame(input logic [15:0] w, input int nbits);
        int i;
        sck_pin = 1'b1;
        step_pin = 1'b0;
        #(HALF_SCK);
        for (i = 15; i > 15 - nbits; i--) begin
            sck_pin = 1'b0;
            dir_pin = w[i];
            #(HALF_SCK);
            sck_pin = 1'b1;
            #(HALF_SCK);
        end
        step_pin = 1'b1;
        dir_pin = 1'b0;
    endtask
endmodule // host_pin_model

/* File: stepper_step_serial_front_end_tb_top.sv */
`timescale 1ns/1ps
module stepper_step_serial_front_end_tb_top;
    import stepper_front_pkg::*;
    typedef struct {
        step_res_t res;
        logic dir;
        logic [5:0] ang;
    } row_t;
    logic ref_clk, sys_rst, step_in, dir_in, usel, pin_rst_n, smode, cfg_v, ov, uvl, sdet;
    logic dap, a_p, a_m, b_p, b_m, en, wv, slp, fo, foe;
    logic [5:0] ang;
    logic [15:0] word;
    step_res_t cfg;
    step_res_t res;
    int bad_count = 0;
    int n_checks = 0;
    int i;
    row_t rows[7] = '{'{RES_HALF, 1'b1, 6'h10}, '{RES_FULL, 1'b1, 6'h20}, '{RES_QUARTER, 1'b0, 6'h1C},
        '{RES_EIGHTH, 1'b0, 6'h1A}, '{RES_SIXTEENTH, 1'b1, 6'h1B}, '{RES_FULL, 1'b0, 6'h0B},
        '{RES_FULL, 1'b0, 6'h3B}};
    host_pin_model host_pin_model_inst (.step_pin(step_in), .dir_pin(dir_in), .sck_pin(usel));
    stepper_step_serial_front_end #(.SLEEP_CYCLES_P(20)) stepper_step_serial_front_end_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .step_in(step_in), .dir_in(dir_in), .microstep_select_in(usel),
        .fault_clear_sleep_n(pin_rst_n), .serial_mode_in(smode), .res_cfg_valid(cfg_v), .res_cfg(cfg),
        .vbb_ov_in(ov), .vreg_uvl_in(uvl), .short_det_in(sdet), .step_angle_r(ang), .dir_applied_r(dap),
        .step_res_r(res), .phase_a_plus(a_p), .phase_a_minus(a_m), .phase_b_plus(b_p), .phase_b_minus(b_m),
        .bridge_enable_r(en), .serial_word_r(word), .serial_word_valid_r(wv), .sleep_active_r(slp),
        .fault_flag_n_out(fo), .fault_flag_n_oe_n(foe));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check_phase(input logic [5:0] a);
        logic ap;
        logic bp;
        ap = (a < 6'h10) || (a >= 6'h30);
        bp = a < 6'h20;
        check("phases", 16'({~ap, ap, ~bp, bp}), 16'({a_p, a_m, b_p, b_m}));
    endtask
    task automatic wait_word(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(negedge ref_clk);
            if (wv === 1'b1) seen = 1'b1;
        end
        check("word_valid", 16'(exp), 16'(seen));
    endtask
    task automatic clr(input int n);
        pin_rst_n = 1'b0;
        cyc(n);
        pin_rst_n = 1'b1;
        cyc(8);
    endtask
    task automatic do_reset(input logic strap);
        host_pin_model_inst.set_strap(strap);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
        check("angle", 16'h8, 16'(ang));
        check("res", 16'(strap ? RES_QUARTER : RES_HALF), 16'(res));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #100us;
        bad_count++;
        end_of_test();
    end
    initial begin
        sys_rst = 1'b1;
        pin_rst_n = 1'b1;
        smode = 1'b0;
        cfg_v = 1'b0;
        cfg = RES_FULL;
        ov = 1'b0;
        uvl = 1'b0;
        sdet = 1'b0;
        cyc(1);
        do_reset(1'b0);
        check("fault_flag_n_oe_n", 16'h1, 16'(foe));
        cyc(2);
        check("enable", 16'h1, 16'(en));
        for (i = 0; i < 7; i++) begin
            cfg = rows[i].res;
            cfg_v = 1'b1;
            cyc(1);
            cfg_v = 1'b0;
            host_pin_model_inst.step_pulse(rows[i].dir, 200);
            cyc(1);
            check("res", 16'(rows[i].res), 16'(res));
            check("angle", 16'(rows[i].ang), 16'(ang));
            check("dir_applied", 16'(rows[i].dir), 16'(dap));
            check_phase(rows[i].ang);
        end
        host_pin_model_inst.set_dir(1'b1);
        cyc(20);
        check("angle", 16'h3B, 16'(ang));
        check("dir_applied", 16'h0, 16'(dap));
        host_pin_model_inst.step_pulse(1'b1, 64);
        cyc(1);
        check("angle", 16'hB, 16'(ang));
        check("dir_applied", 16'h1, 16'(dap));
        host_pin_model_inst.strobe_idle();
        cyc(1);
        check("angle", 16'h1B, 16'(ang));
        smode = 1'b1;
        host_pin_model_inst.noise();
        host_pin_model_inst.send_frame(16'hA5C3, 16);
        wait_word(1'b1);
        check("word", 16'hA5C3, word);
        check("angle", 16'h1B, 16'(ang));
        check("fault_flag_n_out", 16'h0, 16'(fo));
        check("fault_flag_n_oe_n", 16'h1, 16'(foe));
        host_pin_model_inst.send_frame(16'h0F0F, 15);
        wait_word(1'b0);
        check("word", 16'hA5C3, word);
        check("fault_flag_n_oe_n", 16'h0, 16'(foe));
        clr(5);
        check("fault_flag_n_oe_n", 16'h1, 16'(foe));
        check("sleep", 16'h0, 16'(slp));
        pin_rst_n = 1'b0;
        cyc(40);
        check("sleep", 16'h1, 16'(slp));
        check("enable", 16'h0, 16'(en));
        pin_rst_n = 1'b1;
        cyc(8);
        check("sleep", 16'h0, 16'(slp));
        for (i = 0; i < 3; i++) begin
            ov = (i == 0);
            uvl = (i == 1);
            sdet = (i == 2);
            cyc(8);
            check("fault_flag_n_oe_n", 16'h0, 16'(foe));
            check("enable", 16'(i == 2), 16'(en));
            check("phases", (i == 2) ? 16'h9 : 16'h0, 16'({a_p, a_m, b_p, b_m}));
            ov = 1'b0;
            uvl = 1'b0;
            sdet = 1'b0;
            cyc(8);
            check("fault_flag_n_oe_n", 16'(i != 2), 16'(foe));
            check("enable", 16'h1, 16'(en));
        end
        clr(5);
        check("fault_flag_n_oe_n", 16'h1, 16'(foe));
        smode = 1'b0;
        do_reset(1'b1);
        host_pin_model_inst.set_strap(1'b0);
        cyc(8);
        check("res", 16'(RES_QUARTER), 16'(res));
        end_of_test();
    end
endmodule // stepper_step_serial_front_end_tb_top
